// ### oad_pkg.sv
// constants, register map and types for the request message decoder
package oad_pkg;
	localparam logic [7:0]  FMT_BASIC      = 8'h14;
	localparam logic [7:0]  FMT_EXTENDED   = 8'h15;
	localparam logic [7:0]  FMT_DEFAULT    = 8'h00;
	localparam logic [7:0]  FMT_NATIVE     = 8'h64;
	localparam logic [7:0]  FMT_USER       = 8'h66;
	localparam logic [7:0]  FMT_RESET      = 8'h00;

	localparam int          BIT_FWD        = 0;
	localparam int          BIT_REV        = 1;
	localparam int          BIT_FRST       = 2;
	localparam int          BIT_RUN_NET    = 5;
	localparam int          BIT_SPD_NET    = 6;
	localparam int          BIT_TERM_LO    = 2;
	localparam int          BIT_TERM_HI    = 6;
	localparam int          BIT_TERM_F     = 13;
	localparam int          BIT_TERM_R     = 14;
	localparam int          BIT_NATIVE_RST = 15;
	localparam logic [15:0] FREQ_FULL_SCALE = 16'h4E20;

	localparam logic [7:0]  ADR_FORMAT     = 8'h00;
	localparam logic [7:0]  ADR_PTR1       = 8'h04;
	localparam logic [7:0]  ADR_PTR2       = 8'h08;
	localparam logic [7:0]  ADR_PTR3       = 8'h0C;
	localparam logic [7:0]  ADR_PTR4       = 8'h10;
	localparam logic [7:0]  ADR_CONTROL    = 8'h14;
	localparam logic [7:0]  ADR_STATUS     = 8'h18;
	localparam int          CTL_RESTART    = 0;
	localparam logic [15:0] PTR_NONE       = 16'h0000;
	localparam logic [15:0] PTR_RESET      = 16'h0000;

	typedef enum logic [1:0] {OAD_IDLE, OAD_WRITE} oad_state_t;
endpackage

// ### oad_decoder.sv
// request message decoder with wishbone configuration registers
// How it works
// R1 - selector picks basic, extended, native or user layout
// R2 - selector 21 and 0 both mean extended
// R3 - basic: bit0 forward, bit2 alarm reset
// R4 - basic/extended: bytes 2-3 speed, low first
// R5 - extended: bits 0,1,2 forward, reverse, reset
// R6 - extended bit5 selects network run source
// R7 - extended bit6 selects network speed source
// R8 - native: fwd, rev, five terminal commands
// R9 - native byte1 bits 5,6 two more terminals
// R10 - native byte1 bit7 requests fault reset
// R11 - native bytes 2-3 frequency, 20000 full scale
// R12 - user: four words written via four pointers
// R13 - changed pointers apply only after restart
// R14 - duplicate pointer: only lowest one effective
// R15 - ignore unused bits, decode whole message first
//
// Design decisions made here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
module oad_decoder (
	input  wire logic        clk_i,          // 50 MHz system clock
	input  wire logic        rst_i,          // synchronous reset, active high
	input  wire logic [7:0]  wb_adr_i,       // byte address
	input  wire logic [31:0] wb_dat_i,       // write data
	output logic      [31:0] wb_dat_o,       // read data
	input  wire logic        wb_we_i,        // write enable
	input  wire logic [3:0]  wb_sel_i,       // byte enables
	input  wire logic        wb_cyc_i,       // bus cycle
	input  wire logic        wb_stb_i,       // strobe
	output logic             wb_ack_o,       // acknowledge
	input  wire logic        msg_valid_i,    // one-cycle request message strobe
	input  wire logic [63:0] msg_data_i,     // message, byte 0 in bits 7:0
	output logic             msg_ready_o,    // message can be taken
	output logic             run_forward_o,  // run forward command
	output logic             run_reverse_o,  // run reverse command
	output logic             fault_reset_o,  // alarm reset request
	output logic             run_source_request_o,   // run command from network
	output logic             speed_source_request_o, // speed reference from network
	output logic [6:0]       terminal_cmd_o, // terminals 1-5, f, r
	output logic [15:0]      speed_ref_o,    // speed reference, r/min
	output logic [15:0]      freq_cmd_o,     // frequency command, per unit
	output logic             param_wr_o,     // parameter write pulse
	output logic [15:0]      param_code_o,   // parameter written
	output logic [15:0]      param_data_o    // value written
);
	import oad_pkg::*;

	logic [7:0]  format_ff;
	logic [15:0] ptr_pend_ff [4];
	logic [15:0] ptr_act_ff [4];
	logic [3:0]  ptr_en_ff;
	logic        ack_ff;
	logic [31:0] rdata_ff;
	logic [7:0]  msg_count_ff;
	oad_state_t  state_ff;
	logic [1:0]  idx_ff;
	logic [15:0] word_ff [4];
	logic        ready_ff;
	logic        wr_ff;
	logic [15:0] code_ff;
	logic [15:0] data_ff;
	logic        fwd_ff, rev_ff, frst_ff, run_net_ff, spd_net_ff;
	logic [6:0]  term_ff;
	logic [15:0] speed_ff, freq_ff;

	logic        bus_req, bus_wr, restart, take, fmt_ext;

	// duplicate check: a pointer counts only if no lower one names it
	function automatic logic ptr_usable(input logic [15:0] p [4], input int n);
		logic ok;
		ok = (p[n] != PTR_NONE);
		for (int k = 0; k < 4; k++) begin
			if (k < n && p[k] == p[n])
				ok = 1'b0;
		end
		return ok;
	endfunction

	assign bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign bus_wr  = bus_req & wb_we_i;
	assign restart = bus_wr & (wb_adr_i == ADR_CONTROL) & wb_sel_i[0] & wb_dat_i[CTL_RESTART];
	assign take    = msg_valid_i & ready_ff;
	assign fmt_ext = (format_ff == FMT_EXTENDED) || (format_ff == FMT_DEFAULT); // [R2]

	assign wb_ack_o     = ack_ff;
	assign wb_dat_o     = rdata_ff;
	assign msg_ready_o  = ready_ff;
	assign run_forward_o = fwd_ff;
	assign run_reverse_o = rev_ff;
	assign fault_reset_o = frst_ff;
	assign run_source_request_o   = run_net_ff;
	assign speed_source_request_o = spd_net_ff;
	assign terminal_cmd_o = term_ff;
	assign speed_ref_o    = speed_ff;
	assign freq_cmd_o     = freq_ff;
	assign param_wr_o     = wr_ff;
	assign param_code_o   = code_ff;
	assign param_data_o   = data_ff;

	////////////////////////////////////////////////////////////////////////////////
	// bus slave: answer one cycle after the strobe, unmapped reads give zero

	always_ff @(posedge clk_i) begin
		if (rst_i)
			ack_ff <= 1'b0;
		else
			ack_ff <= bus_req;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_ff <= 32'h00000000;
		end else if (bus_req) begin
			unique case (wb_adr_i)
				ADR_FORMAT:  rdata_ff <= {24'h000000, format_ff};
				ADR_PTR1:    rdata_ff <= {16'h0000, ptr_pend_ff[0]};
				ADR_PTR2:    rdata_ff <= {16'h0000, ptr_pend_ff[1]};
				ADR_PTR3:    rdata_ff <= {16'h0000, ptr_pend_ff[2]};
				ADR_PTR4:    rdata_ff <= {16'h0000, ptr_pend_ff[3]};
				ADR_STATUS:  rdata_ff <= {16'h0000, msg_count_ff, ptr_en_ff,
					3'h0, (state_ff == OAD_WRITE)};
				default:     rdata_ff <= 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			format_ff <= FMT_RESET; // [R2]
		end else if (bus_wr && wb_adr_i == ADR_FORMAT && wb_sel_i[0]) begin
			format_ff <= wb_dat_i[7:0];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++)
				ptr_pend_ff[i] <= PTR_RESET;
		end else if (bus_wr) begin
			for (int i = 0; i < 4; i++) begin
				if (wb_adr_i == ADR_PTR1 + 8'(4 * i)) begin
					if (wb_sel_i[0])
						ptr_pend_ff[i][7:0] <= wb_dat_i[7:0];
					if (wb_sel_i[1])
						ptr_pend_ff[i][15:8] <= wb_dat_i[15:8];
				end
			end
		end
	end

	// pending pointers take effect only on a drive restart
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			for (int i = 0; i < 4; i++)
				ptr_act_ff[i] <= PTR_RESET;
			ptr_en_ff <= 4'h0;
		end else if (restart) begin
			for (int i = 0; i < 4; i++) begin
				ptr_act_ff[i] <= ptr_pend_ff[i]; // [R13]
				ptr_en_ff[i]  <= ptr_usable(ptr_pend_ff, i); // [R14]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// command decode: whole message in one cycle, unused bits never looked at

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fwd_ff     <= 1'b0;
			rev_ff     <= 1'b0;
			frst_ff    <= 1'b0;
			run_net_ff <= 1'b0;
			spd_net_ff <= 1'b0;
			term_ff    <= 7'h00;
			speed_ff   <= 16'h0000;
			freq_ff    <= 16'h0000;
		end else if (take) begin // [R15]
			if (format_ff == FMT_BASIC) begin // [R1]
				fwd_ff     <= msg_data_i[BIT_FWD]; // [R3]
				rev_ff     <= 1'b0;
				frst_ff    <= msg_data_i[BIT_FRST]; // [R3]
				run_net_ff <= 1'b1;
				spd_net_ff <= 1'b1;
				speed_ff   <= msg_data_i[31:16]; // [R4]
			end else if (fmt_ext) begin // [R1]
				fwd_ff     <= msg_data_i[BIT_FWD]; // [R5]
				rev_ff     <= msg_data_i[BIT_REV]; // [R5]
				frst_ff    <= msg_data_i[BIT_FRST]; // [R5]
				run_net_ff <= msg_data_i[BIT_RUN_NET]; // [R6]
				spd_net_ff <= msg_data_i[BIT_SPD_NET]; // [R7]
				speed_ff   <= msg_data_i[31:16]; // [R4]
			end else if (format_ff == FMT_NATIVE) begin // [R1]
				fwd_ff     <= msg_data_i[BIT_FWD]; // [R8]
				rev_ff     <= msg_data_i[BIT_REV]; // [R8]
				term_ff    <= {msg_data_i[BIT_TERM_R], msg_data_i[BIT_TERM_F],
					msg_data_i[BIT_TERM_HI:BIT_TERM_LO]}; // [R8] [R9]
				frst_ff    <= msg_data_i[BIT_NATIVE_RST]; // [R10]
				run_net_ff <= 1'b1;
				spd_net_ff <= 1'b1;
				freq_ff    <= msg_data_i[31:16]; // [R11]
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// user layout: four slots stepped in pointer order, one per cycle, each word written only if its pointer is enabled

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_ff <= OAD_IDLE;
			idx_ff   <= 2'h0;
			ready_ff <= 1'b0;
			wr_ff    <= 1'b0;
			code_ff  <= 16'h0000;
			data_ff  <= 16'h0000;
			for (int i = 0; i < 4; i++)
				word_ff[i] <= 16'h0000;
		end else begin
			wr_ff <= 1'b0;
			unique case (state_ff)
				OAD_IDLE: begin
					ready_ff <= 1'b1;
					if (take && format_ff == FMT_USER) begin // [R1]
						for (int i = 0; i < 4; i++)
							word_ff[i] <= msg_data_i[16*i +: 16]; // [R12]
						state_ff <= OAD_WRITE;
						idx_ff   <= 2'h0;
						ready_ff <= 1'b0;
					end
				end
				OAD_WRITE: begin
					// skipped slots still cost a cycle: fixed timing per message
					wr_ff   <= ptr_en_ff[idx_ff]; // [R12] [R14]
					code_ff <= ptr_act_ff[idx_ff];
					data_ff <= word_ff[idx_ff];
					idx_ff  <= idx_ff + 2'h1;
					if (idx_ff == 2'h3) begin
						state_ff <= OAD_IDLE;
						ready_ff <= 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			msg_count_ff <= 8'h00;
		else if (take)
			msg_count_ff <= msg_count_ff + 8'h01;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks

	chk_basic_fwd_bit: assert property (@(posedge clk_i) disable iff (rst_i) // [R3]
		take && format_ff == FMT_BASIC |=> run_forward_o == $past(msg_data_i[0])
			&& fault_reset_o == $past(msg_data_i[2]) && !run_reverse_o)
		else $error("basic layout run or reset bit wrong");

	chk_default_is_ext: assert property (@(posedge clk_i) disable iff (rst_i) // [R2]
		take && format_ff == FMT_DEFAULT |=> run_reverse_o == $past(msg_data_i[1])
			&& speed_source_request_o == $past(msg_data_i[6]))
		else $error("selector zero not decoded as extended");

	chk_ext_run_src: assert property (@(posedge clk_i) disable iff (rst_i) // [R6]
		take && format_ff == FMT_EXTENDED |=> run_source_request_o == $past(msg_data_i[5]))
		else $error("run source request wrong");

	chk_ext_spd_src: assert property (@(posedge clk_i) disable iff (rst_i) // [R7]
		take && format_ff == FMT_EXTENDED |=> speed_source_request_o == $past(msg_data_i[6]))
		else $error("speed source request wrong");

	chk_speed_ref_order: assert property (@(posedge clk_i) disable iff (rst_i) // [R4]
		take && (format_ff == FMT_BASIC || fmt_ext)
			|=> speed_ref_o == {$past(msg_data_i[31:24]), $past(msg_data_i[23:16])})
		else $error("speed reference byte order wrong");

	chk_native_terms: assert property (@(posedge clk_i) disable iff (rst_i) // [R9]
		take && format_ff == FMT_NATIVE |=> terminal_cmd_o ==
			{$past(msg_data_i[14]), $past(msg_data_i[13]), $past(msg_data_i[6:2])}
			&& fault_reset_o == $past(msg_data_i[15]))
		else $error("native terminal or reset bits wrong");

	chk_native_freq: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		take && format_ff == FMT_NATIVE |=> freq_cmd_o == $past(msg_data_i[31:16]))
		else $error("frequency command wrong");

	chk_user_first_word: assert property (@(posedge clk_i) disable iff (rst_i) // [R12]
		take && format_ff == FMT_USER && ptr_en_ff[0] && !restart
			|=> ##1 param_wr_o && param_data_o == $past(msg_data_i[15:0], 2)
			&& param_code_o == $past(ptr_act_ff[0], 2))
		else $error("first user word not written");

	chk_user_busy_len: assert property (@(posedge clk_i) disable iff (rst_i) // [R15]
		take && format_ff == FMT_USER |=> !msg_ready_o [*4] ##1 msg_ready_o)
		else $error("user write sequence length wrong");

	chk_ptr_restart: assert property (@(posedge clk_i) disable iff (rst_i) // [R13]
		!restart |=> $stable(ptr_en_ff) && ptr_act_ff[0] == $past(ptr_act_ff[0]))
		else $error("pointers changed without restart");

	chk_dup_pointer: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
		restart && ptr_pend_ff[1] == ptr_pend_ff[0] |=> !ptr_en_ff[1])
		else $error("duplicate pointer left effective");

	chk_dup_third: assert property (@(posedge clk_i) disable iff (rst_i) // [R14]
		restart && ptr_pend_ff[2] == ptr_pend_ff[0] && ptr_pend_ff[0] != PTR_NONE
			|=> !ptr_en_ff[2] && ptr_en_ff[0])
		else $error("third pointer duplicate left effective");
endmodule

// ### oad_master_model.sv
// fieldbus master model that hands request messages to the decoder
`timescale 1ns/10ps
module oad_master_model (
	input  wire logic        clk_i,   // system clock
	input  wire logic        rst_i,   // synchronous reset
	input  wire logic        ready_i, // decoder can take a message
	output logic             valid_o, // one-cycle message strobe
	output logic [63:0]      data_o   // message bytes, byte 0 low
);
	initial begin
		valid_o = 1'b0;
		data_o  = 64'h0;
	end
	// no limit of its own: the bench watchdog ends a hang
	task automatic send(input logic [63:0] d);
		@(posedge clk_i);
		while (ready_i !== 1'b1 || rst_i)
			@(posedge clk_i);
		valid_o <= 1'b1;
		data_o  <= d;
		@(posedge clk_i);
		valid_o <= 1'b0;
		// idle lines show the inverse, so a stale copy cannot pass
		data_o  <= ~d;
	endtask
endmodule

// ### test_output_assembly_decoder.sv
// testbench: format decoding, pointer writes and register access
`timescale 1ns/10ps
module test_output_assembly_decoder;
	import oad_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic        wb_we_i = 1'b0;
	logic [3:0]  wb_sel_i = 4'h0;
	logic        wb_cyc_i = 1'b0;
	logic        wb_stb_i = 1'b0;
	logic [31:0] wb_dat_o, rd;
	logic        wb_ack_o, msg_valid_i, msg_ready_o, run_forward_bit, run_reverse_bit, frst, rsrc, ssrc, wr;
	logic [63:0] msg_data_i;
	logic [6:0]  term;
	logic [15:0] spd, frq, code, wdat;
	logic [31:0] wq[$];
	int          mismatches = 0;
	int          checks = 0;
	wire  [11:0] flags = {run_forward_bit, run_reverse_bit, frst, rsrc, ssrc, term};
	always #10 clk_i = ~clk_i;
	oad_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .msg_valid_i(msg_valid_i),
		.msg_data_i(msg_data_i), .msg_ready_o(msg_ready_o), .run_forward_o(run_forward_bit),
		.run_reverse_o(run_reverse_bit), .fault_reset_o(frst), .run_source_request_o(rsrc),
		.speed_source_request_o(ssrc), .terminal_cmd_o(term), .speed_ref_o(spd),
		.freq_cmd_o(frq), .param_wr_o(wr), .param_code_o(code), .param_data_o(wdat));
	oad_master_model u_master (.clk_i(clk_i), .rst_i(rst_i), .ready_i(msg_ready_o),
		.valid_o(msg_valid_i), .data_o(msg_data_i));
	always @(posedge clk_i) begin
		if (wr === 1'b1)
			wq.push_back({code, wdat});
	end
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", checks, mismatches);
		if (mismatches == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// single classic cycle, held until ack is sampled
	task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_adr_i <= a;
		wb_we_i  <= we;
		wb_sel_i <= 4'hF;
		wb_dat_i <= d;
		@(posedge clk_i);
		// only the watchdog ends a wait for ack
		while (wb_ack_o !== 1'b1)
			@(posedge clk_i);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask
	// byte 1 kept at 00 by the stimulus itself in the basic and extended layouts only
	task automatic step(input logic [7:0] f, input logic [31:0] m, input logic [11:0] ef,
		input logic [15:0] es, input logic [15:0] eq);
		wb(ADR_FORMAT, 1'b1, {24'h0, f});
		wb(ADR_FORMAT, 1'b0, 32'h0);
		chk(rd, {24'h0, f});
		u_master.send({32'h0, m});
		repeat (2) @(posedge clk_i);
		chk({20'h0, flags}, {20'h0, ef});
		chk({spd, frq}, {es, eq});
	endtask
	initial begin
		repeat (20000) @(posedge clk_i);
		mismatches++;
		end_of_test();
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(ADR_FORMAT, 1'b0, 32'h0);
		chk(rd, {24'h0, FMT_RESET});
		wb(8'h1C, 1'b0, 32'h0);
		chk(rd, 32'h0);
		wb(ADR_CONTROL, 1'b0, 32'h0);
		chk(rd, 32'h0);
		$display("test registers done");
		step(FMT_DEFAULT, 32'h0708_0067, 12'hF80, 16'h0708, 16'h0000);
		step(FMT_DEFAULT, 32'h012C_0098, 12'h000, 16'h012C, 16'h0000);
		step(FMT_EXTENDED, 32'h0708_0062, 12'h580, 16'h0708, 16'h0000);
		step(FMT_BASIC, 32'h1234_00FF, 12'hB80, 16'h1234, 16'h0000);
		step(FMT_NATIVE, 32'h4E20_E07D, 12'hBFF, 16'h1234, 16'h4E20);
		step(FMT_NATIVE, 32'h0001_1F2A, 12'h58A, 16'h1234, 16'h0001);
		step(8'h33, 32'hFFFF_FFFF, 12'h58A, 16'h1234, 16'h0001);
		$display("test layouts done");
		wb(ADR_PTR1, 1'b1, 32'h0101);
		wb(ADR_PTR2, 1'b1, 32'h0202);
		wb(ADR_PTR3, 1'b1, 32'h0101);
		wb(ADR_PTR4, 1'b1, 32'h0404);
		wb(ADR_FORMAT, 1'b1, {24'h0, FMT_USER});
		u_master.send(64'h4444_3333_2222_1111);
		repeat (8) @(posedge clk_i);
		chk(wq.size(), 32'h0);
		// operator restart makes the pending pointers live
		wb(ADR_CONTROL, 1'b1, 32'h1);
		wb(ADR_STATUS, 1'b0, 32'h0);
		chk(rd & 32'hF0, 32'hB0);
		wb(ADR_PTR4, 1'b1, 32'h0505);
		u_master.send(64'h4444_3333_2222_1111);
		repeat (8) @(posedge clk_i);
		chk(wq.size(), 32'h3);
		while (wq.size() < 3)
			wq.push_back(32'h0);
		chk(wq[0], 32'h0101_1111);
		chk(wq[1], 32'h0202_2222);
		chk(wq[2], 32'h0404_4444);
		$display("test user layout done");
		end_of_test();
	end
endmodule
